/* src/strc_interval_timer.sv */
// Interval timer producing one sample tick per programmed interval
`timescale 1ns/1ps
`default_nettype none
module strc_interval_timer #(
   parameter int STEP_CYCLES = strc_pkg::STEP_CYC
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   strc_tick_if.tmr tk
);
   logic [31:0] pre_ff;
   logic [15:0] steps_ff;
   logic tick_ff;

   // Prescaler of one 10 ms step; restarts when timing stops
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         pre_ff <= 32'h0000_0000;
         steps_ff <= 16'h0000;
         tick_ff <= 1'b0;
      end else if (!tk.run) begin
         pre_ff <= 32'h0000_0000;
         steps_ff <= 16'h0000;
         tick_ff <= 1'b0;
      end else begin
         tick_ff <= 1'b0;
         if (pre_ff == 32'(STEP_CYCLES - 1)) begin
            pre_ff <= 32'h0000_0000;
            if (steps_ff + 16'h0001 >= tk.interval) begin
               steps_ff <= 16'h0000;
               tick_ff <= 1'b1;
            end else begin
               steps_ff <= steps_ff + 16'h0001;
            end
         end else begin
            pre_ff <= pre_ff + 32'h0000_0001;
         end
      end
   end

   assign tk.tick = tick_ff;
endmodule : strc_interval_timer
`default_nettype wire

/* src/strc_pkg.sv */
// Package with register map, field layout and timing constants of the trace recorder
package strc_pkg;
   // Register byte offsets
   localparam logic [5:0] OFS_CTRL = 6'h00;
   localparam logic [5:0] OFS_INTERVAL = 6'h04;
   localparam logic [5:0] OFS_DELAY = 6'h08;
   localparam logic [5:0] OFS_STATUS = 6'h0C;
   localparam logic [5:0] OFS_COUNT = 6'h10;
   localparam logic [5:0] OFS_RD_INDEX = 6'h14;
   localparam logic [5:0] OFS_RD_BITS = 6'h18;
   localparam logic [5:0] OFS_RD_WORD0 = 6'h1C;
   localparam logic [5:0] OFS_RD_WORD1 = 6'h20;
   localparam logic [5:0] OFS_RD_WORD2 = 6'h24;
   localparam logic [5:0] OFS_IRQ_STAT = 6'h28;
   localparam logic [5:0] OFS_IRQ_EN = 6'h2C;
   localparam logic [5:0] OFS_IRQ_CLR = 6'h30;
   localparam logic [5:0] OFS_START_PTR = 6'h34;
   // Control register bits
   localparam int CTRL_START = 0;
   localparam int CTRL_STOP_REQ = 1;
   localparam int CTRL_ABORT = 2;
   // Status register bits
   localparam int ST_MODE = 0;
   localparam int ST_END = 1;
   localparam int ST_TRIG = 2;
   localparam int ST_EN = 3;
   // Interrupt status bits
   localparam int IRQ_END = 0;
   localparam int IRQ_TRIG = 1;
   localparam int IRQ_SAMPLE = 2;
   localparam int IRQ_W = 3;
   // Reset values and interval limit
   localparam logic [15:0] INTERVAL_RST = 16'h0000;
   localparam logic [15:0] DELAY_RST = 16'h0000;
   localparam logic [15:0] INTERVAL_MAX = 16'h0BB8;
   // Timing: one interval step in ns, clock period in ns
   localparam int STEP_NS = 10_000_000;
   localparam int CLK_NS = 10;
   localparam int STEP_CYC = STEP_NS / CLK_NS;
   localparam int SAMPLES_DEF = 1000;
   localparam logic [31:0] BUS_ZERO = 32'h0000_0000;
   typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_POST} strc_state_t;
endpackage : strc_pkg

/* src/strc_recorder.sv */
// Sampling trace recorder: capture, trigger delay, circular store and register slave
//
// The Avalon-MM register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module strc_recorder #(
   parameter int SAMPLES = strc_pkg::SAMPLES_DEF,
   parameter int STEP_CYCLES = strc_pkg::STEP_CYC
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [15:0] sample_bits,
   input wire logic [15:0] sample_word0,
   input wire logic [15:0] sample_word1,
   input wire logic [15:0] sample_word2,
   input wire logic sample_capture_instruction,
   input wire logic stop_trigger_instruction,
   output logic irq
);
   localparam int AW = $clog2(SAMPLES);
   localparam logic [AW-1:0] LAST = AW'(SAMPLES - 1);

   // ==========================================================
   // Storage
   logic [15:0] mem_bits [SAMPLES];
   logic [15:0] mem_w0 [SAMPLES];
   logic [15:0] mem_w1 [SAMPLES];
   logic [15:0] mem_w2 [SAMPLES];

   strc_pkg::strc_state_t state_ff;
   logic [15:0] interval_ff;
   logic [15:0] delay_ff;
   logic [15:0] post_cnt_ff;
   logic [AW-1:0] wr_ptr_ff;
   logic [AW:0] count_ff;
   logic [AW-1:0] rd_idx_ff;
   logic mode_ff, end_ff, trig_ff, en_ff;
   logic [strc_pkg::IRQ_W-1:0] irq_stat_ff, irq_en_ff;
   logic [31:0] rdata_ff;
   logic rvalid_ff;
   logic [15:0] rd_bits_ff, rd_w0_ff, rd_w1_ff, rd_w2_ff;

   strc_tick_if tk ();

   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      ptr_inc = (p == LAST) ? '0 : p + AW'(1);
   endfunction : ptr_inc

   // Sum stays below twice the depth, so one subtraction wraps it
   function automatic logic [AW-1:0] ptr_add(input logic [AW-1:0] p, input logic [AW-1:0] n);
      logic [AW:0] s;
      s = {1'b0, p} + {1'b0, n};
      ptr_add = (s > {1'b0, LAST}) ? AW'(s - (AW+1)'(SAMPLES)) : s[AW-1:0];
   endfunction : ptr_add

   // ==========================================================
   // Bus decode
   logic wr_hit, rd_hit;
   assign wr_hit = avs_write && avs_byteenable[0];
   assign rd_hit = avs_read && !rvalid_ff;
   // Reads take one wait cycle so the storage port is registered
   assign avs_waitrequest = avs_read && !rvalid_ff;

   logic wr_ctrl, wr_irq_clr;
   assign wr_ctrl = wr_hit && (avs_address == strc_pkg::OFS_CTRL);
   assign wr_irq_clr = wr_hit && (avs_address == strc_pkg::OFS_IRQ_CLR);

   logic start_cmd, stop_cmd, abort_cmd;
   assign start_cmd = wr_ctrl && avs_writedata[strc_pkg::CTRL_START];
   assign stop_cmd = wr_ctrl && avs_writedata[strc_pkg::CTRL_STOP_REQ];
   assign abort_cmd = wr_ctrl && avs_writedata[strc_pkg::CTRL_ABORT];

   // ==========================================================
   // Sample and trigger sources
   logic running, sample_evt, trig_evt;
   assign running = (state_ff != strc_pkg::ST_IDLE);
   // Mode fixed at start so the sources never mix
   assign sample_evt = running &&
      (mode_ff ? tk.tick : sample_capture_instruction);
   assign trig_evt = (state_ff == strc_pkg::ST_RUN) &&
      (stop_cmd || stop_trigger_instruction);

   assign tk.run = running && mode_ff;
   assign tk.interval = interval_ff;

   strc_interval_timer #(.STEP_CYCLES(STEP_CYCLES)) u_timer (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .tk(tk.tmr)
   );

   // ==========================================================
   // Configuration registers
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         interval_ff <= strc_pkg::INTERVAL_RST;
         delay_ff <= strc_pkg::DELAY_RST;
         rd_idx_ff <= '0;
         irq_en_ff <= '0;
      end else if (wr_hit) begin
         unique case (avs_address)
            strc_pkg::OFS_INTERVAL: begin
               // Values beyond the top step clamp to it
               interval_ff <= (avs_writedata[15:0] > strc_pkg::INTERVAL_MAX) ?
                  strc_pkg::INTERVAL_MAX : avs_writedata[15:0];
            end
            strc_pkg::OFS_DELAY: delay_ff <= avs_writedata[15:0];
            strc_pkg::OFS_RD_INDEX: begin
               // Only the low AW index bits are kept; a value past the last slot clamps to it
               rd_idx_ff <= (avs_writedata[AW-1:0] > LAST) ? LAST : avs_writedata[AW-1:0];
            end
            strc_pkg::OFS_IRQ_EN: irq_en_ff <= avs_writedata[strc_pkg::IRQ_W-1:0];
            default: begin
            end
         endcase
      end
   end

   // ==========================================================
   // Sequencer
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff <= strc_pkg::ST_IDLE;
         post_cnt_ff <= 16'h0000;
      end else if (abort_cmd) begin
         // Post counter left as is; the next trigger reloads it
         state_ff <= strc_pkg::ST_IDLE;
      end else begin
         unique case (state_ff)
            strc_pkg::ST_IDLE: begin
               if (start_cmd) begin
                  state_ff <= strc_pkg::ST_RUN;
               end
            end
            strc_pkg::ST_RUN: begin
               if (trig_evt) begin
                  post_cnt_ff <= delay_ff;
                  // Zero delay halts at once
                  state_ff <= (delay_ff == 16'h0000) ?
                     strc_pkg::ST_IDLE : strc_pkg::ST_POST;
               end
            end
            strc_pkg::ST_POST: begin
               if (sample_evt) begin
                  post_cnt_ff <= post_cnt_ff - 16'h0001;
                  if (post_cnt_ff == 16'h0001) begin
                     state_ff <= strc_pkg::ST_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // ==========================================================
   // Status flags
   logic halt_now;
   assign halt_now = running && !abort_cmd &&
      ((trig_evt && delay_ff == 16'h0000) ||
       (state_ff == strc_pkg::ST_POST && sample_evt && post_cnt_ff == 16'h0001));

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         mode_ff <= 1'b0;
         end_ff <= 1'b0;
         trig_ff <= 1'b0;
         en_ff <= 1'b0;
      end else if (!running && start_cmd) begin
         mode_ff <= (interval_ff != 16'h0000);
         end_ff <= 1'b0;
         trig_ff <= 1'b0;
         en_ff <= 1'b1;
      end else begin
         if (trig_evt) begin
            trig_ff <= 1'b1;
         end
         // Abort ends the trace too, but raises no end interrupt
         if (halt_now || (running && abort_cmd)) begin
            end_ff <= 1'b1;
            en_ff <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Circular store
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr_ff <= '0;
         count_ff <= '0;
      end else if (!running && start_cmd) begin
         wr_ptr_ff <= '0;
         count_ff <= '0;
      end else if (sample_evt) begin
         wr_ptr_ff <= ptr_inc(wr_ptr_ff);
         if (count_ff != (AW+1)'(SAMPLES)) begin
            count_ff <= count_ff + (AW+1)'(1);
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sample_evt) begin
         mem_bits[wr_ptr_ff] <= sample_bits;
         mem_w0[wr_ptr_ff] <= sample_word0;
         mem_w1[wr_ptr_ff] <= sample_word1;
         mem_w2[wr_ptr_ff] <= sample_word2;
      end
   end

   // Oldest sample sits at the write pointer once the store has wrapped
   logic [AW-1:0] oldest;
   assign oldest = (count_ff == (AW+1)'(SAMPLES)) ? wr_ptr_ff : '0;

   // Two stages: index to storage, storage to read data; the host
   // waits two cycles after moving the index before it reads a sample
   always_ff @(posedge clk_sys) begin
      rd_bits_ff <= mem_bits[ptr_add(oldest, rd_idx_ff)];
      rd_w0_ff <= mem_w0[ptr_add(oldest, rd_idx_ff)];
      rd_w1_ff <= mem_w1[ptr_add(oldest, rd_idx_ff)];
      rd_w2_ff <= mem_w2[ptr_add(oldest, rd_idx_ff)];
   end

   // ==========================================================
   // Interrupts: set wins over clear
   logic [strc_pkg::IRQ_W-1:0] irq_set;
   always_comb begin
      irq_set = '0;
      irq_set[strc_pkg::IRQ_END] = halt_now;
      irq_set[strc_pkg::IRQ_TRIG] = trig_evt;
      irq_set[strc_pkg::IRQ_SAMPLE] = sample_evt;
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         irq_stat_ff <= '0;
      end else begin
         irq_stat_ff <= (irq_stat_ff &
            ~(wr_irq_clr ? avs_writedata[strc_pkg::IRQ_W-1:0] : '0)) | irq_set;
      end
   end

   assign irq = |(irq_stat_ff & irq_en_ff);

   // ==========================================================
   // Read data
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_ff <= strc_pkg::BUS_ZERO;
         rvalid_ff <= 1'b0;
      end else begin
         rvalid_ff <= rd_hit;
         if (rd_hit) begin
            rdata_ff <= strc_pkg::BUS_ZERO;
            unique case (avs_address)
               strc_pkg::OFS_INTERVAL: rdata_ff <= {16'h0000, interval_ff};
               strc_pkg::OFS_DELAY: rdata_ff <= {16'h0000, delay_ff};
               strc_pkg::OFS_STATUS: begin
                  rdata_ff[strc_pkg::ST_MODE] <= mode_ff;
                  rdata_ff[strc_pkg::ST_END] <= end_ff;
                  rdata_ff[strc_pkg::ST_TRIG] <= trig_ff;
                  rdata_ff[strc_pkg::ST_EN] <= en_ff;
               end
               strc_pkg::OFS_COUNT: rdata_ff <= 32'(count_ff);
               strc_pkg::OFS_RD_INDEX: rdata_ff <= 32'(rd_idx_ff);
               strc_pkg::OFS_RD_BITS: rdata_ff <= {16'h0000, rd_bits_ff};
               strc_pkg::OFS_RD_WORD0: rdata_ff <= {16'h0000, rd_w0_ff};
               strc_pkg::OFS_RD_WORD1: rdata_ff <= {16'h0000, rd_w1_ff};
               strc_pkg::OFS_RD_WORD2: rdata_ff <= {16'h0000, rd_w2_ff};
               strc_pkg::OFS_IRQ_STAT: rdata_ff <= 32'(irq_stat_ff);
               strc_pkg::OFS_IRQ_EN: rdata_ff <= 32'(irq_en_ff);
               strc_pkg::OFS_START_PTR: rdata_ff <= 32'(oldest);
               default: rdata_ff <= strc_pkg::BUS_ZERO;
            endcase
         end
      end
   end

   assign avs_readdata = rdata_ff;
endmodule : strc_recorder
`default_nettype wire

/* src/strc_tick_if.sv */
// Interface carrying the interval timer control and tick between modules
`timescale 1ns/1ps
`default_nettype none
interface strc_tick_if;
   logic run;
   logic [15:0] interval;
   logic tick;
   modport ctl (output run, output interval, input tick);
   modport tmr (input run, input interval, output tick);
endinterface : strc_tick_if
`default_nettype wire

/* test/strc_host_model.sv */
// Host tool model: bus master and trace buffer readout
`timescale 1ns/1ps
`default_nettype none
module strc_host_model (
   input wire logic clk_sys,
   input wire logic avs_waitrequest,
   input wire logic [31:0] avs_readdata,
   output logic [5:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata,
   output logic [3:0] avs_byteenable
);
   // ====================
   // Transfers
   logic [63:0] rec[$];
   initial begin
      avs_address = '0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = '0;
      avs_byteenable = 4'hF;
   end
   // Entered just after an edge; one idle edge after release avoids double drive
   task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d,
         input logic [3:0] be, output logic [31:0] q);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= w;
      avs_read <= !w;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0) begin
         @(posedge clk_sys);
      end
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk_sys);
   endtask : xfer
   task automatic dump(input int n);
      logic [31:0] q;
      logic [63:0] r;
      rec.delete();
      for (int i = 0; i < n; i++) begin
         xfer(1'b1, strc_pkg::OFS_RD_INDEX, 32'(i), 4'hF, q);
         repeat (2) @(posedge clk_sys);
         for (int k = 0; k < 4; k++) begin
            xfer(1'b0, strc_pkg::OFS_RD_BITS + 6'(4 * k), 32'h0, 4'hF, q);
            r = {r[47:0], q[15:0]};
         end
         rec.push_back(r);
      end
   endtask : dump
endmodule : strc_host_model
`default_nettype wire

/* test/strc_recorder_checker.sv */
// Concurrent checks on the recorder's bus and interrupt ports
`timescale 1ns/1ps
`default_nettype none
module strc_recorder_checker (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic irq
);
   // ====================
   // Bus and interrupt
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);
   sequence rd_issue;
      avs_read && avs_waitrequest;
   endsequence
   sequence rd_done;
      avs_read && !avs_waitrequest;
   endsequence
   sequence en_wr;
      avs_write && avs_address == strc_pkg::OFS_IRQ_EN;
   endsequence
   rd_one_wait_a: assert property (rd_issue |=> rd_done)
      else $error("read not answered after exactly one wait cycle");
   wr_no_wait_a: assert property (avs_write |-> !avs_waitrequest)
      else $error("write was stalled");
   idle_no_wait_a: assert property (!avs_read |-> !avs_waitrequest)
      else $error("wait asserted without a read");
   rd_upper_zero_a: assert property (rd_done |-> avs_readdata[31:16] == 16'h0000)
      else $error("upper read data not zero");
   unmapped_zero_a: assert property (rd_issue and avs_address > 6'h34 |=> avs_readdata == '0)
      else $error("unmapped read not zero");
   rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
      else $error("read data changed without a read");
   irq_mask_a: assert property (en_wr and avs_byteenable[0] && avs_writedata[2:0] == 3'h0 |=> !irq)
      else $error("interrupt high with all enables off");
   irq_keep_a: assert property (en_wr and !avs_byteenable[0] && irq |=> irq)
      else $error("byte-disabled enable write changed interrupt");
endmodule : strc_recorder_checker
bind strc_recorder strc_recorder_checker u_chk (.clk_sys, .sys_rst, .avs_address, .avs_read,
   .avs_write, .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest, .irq);
`default_nettype wire

/* test/tb_top.sv */
// Self-checking bench for the sampling trace recorder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // ====================
   // Bench
   localparam int NS = 8;
   logic clk_sys, sys_rst, cap, trg, avs_read, avs_write, avs_waitrequest, irq;
   logic [15:0] sample_bits, sample_word0, sample_word1, sample_word2, seed;
   logic [5:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [3:0] avs_byteenable;
   logic [63:0] exp_q[$];
   logic [15:0] iv[5] = '{16'h0001, 16'h0BB8, 16'h0BB9, 16'hFFFF, 16'h0000};
   int err_count, compares, cyc;
   strc_recorder #(.SAMPLES(NS), .STEP_CYCLES(10)) dut (.clk_sys, .sys_rst, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
      .sample_bits, .sample_word0, .sample_word1, .sample_word2, .irq,
      .sample_capture_instruction(cap), .stop_trigger_instruction(trg));
   strc_host_model u_host (.clk_sys, .avs_waitrequest, .avs_readdata, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_byteenable);
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
      u_host.xfer(1'b1, a, d, be, q);
   endtask : wr
   task automatic rc(input string nm, input logic [5:0] a, input logic [31:0] e);
      u_host.xfer(1'b0, a, 32'h0, 4'hF, q);
      chk(nm, e, q);
   endtask : rc
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   function automatic logic [31:0] st(input logic m, input logic e, input logic t, input logic n);
      logic [31:0] r;
      r = '0;
      r[strc_pkg::ST_MODE] = m;
      r[strc_pkg::ST_END] = e;
      r[strc_pkg::ST_TRIG] = t;
      r[strc_pkg::ST_EN] = n;
      return r;
   endfunction : st
   // Back-to-back capture pulses with fresh random sample data
   task automatic smp(input int n, input bit keep);
      logic [15:0] v[4];
      for (int i = 0; i < n; i++) begin
         for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            v[k] = seed;
         end
         sample_bits <= v[0];
         sample_word0 <= v[1];
         sample_word1 <= v[2];
         sample_word2 <= v[3];
         cap <= 1'b1;
         if (keep) exp_q.push_back({v[0], v[1], v[2], v[3]});
         @(posedge clk_sys);
      end
      cap <= 1'b0;
      @(posedge clk_sys);
   endtask : smp
   task automatic pulse_trg;
      trg <= 1'b1;
      @(posedge clk_sys);
      trg <= 1'b0;
   endtask : pulse_trg
   task automatic end_of_test;
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_of_test
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         end_of_test();
      end
   end
   initial begin
      {sys_rst, cap, trg, seed} = {1'b1, 1'b0, 1'b0, 16'h001A};
      {sample_bits, sample_word0, sample_word1, sample_word2} = '0;
      repeat (3) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      pulse_trg();
      wr(strc_pkg::OFS_STATUS, 32'hF);
      rc("status", strc_pkg::OFS_STATUS, st(0, 0, 0, 0));
      rc("delay", strc_pkg::OFS_DELAY, 32'h0);
      rc("unmapped", 6'h38, 32'h0);
      foreach (iv[i]) begin
         wr(strc_pkg::OFS_INTERVAL, {16'h0, iv[i]});
         rc("interval", strc_pkg::OFS_INTERVAL, (iv[i] > 16'h0BB8) ? 32'h0BB8 : iv[i]);
      end
      wr(strc_pkg::OFS_DELAY, 32'h2);
      wr(strc_pkg::OFS_CTRL, 32'h1);
      rc("status", strc_pkg::OFS_STATUS, st(0, 0, 0, 1));
      smp(NS + 3, 1);
      pulse_trg();
      rc("status", strc_pkg::OFS_STATUS, st(0, 0, 1, 1));
      smp(2, 1);
      smp(1, 0);
      rc("status", strc_pkg::OFS_STATUS, st(0, 1, 1, 0));
      rc("count", strc_pkg::OFS_COUNT, NS);
      rc("start_ptr", strc_pkg::OFS_START_PTR, (NS + 3 + 2) % NS);
      chk("irq", 0, irq);
      u_host.dump(NS);
      for (int i = 0; i < NS; i++) begin
         chk("record", exp_q[exp_q.size() - NS + i], u_host.rec[i]);
      end
      rc("rd_index", strc_pkg::OFS_RD_INDEX, NS - 1);
      wr(strc_pkg::OFS_IRQ_EN, 32'h1 << strc_pkg::IRQ_END);
      chk("irq", 1, irq);
      wr(strc_pkg::OFS_IRQ_EN, 32'h0, 4'hE);
      chk("irq", 1, irq);
      wr(strc_pkg::OFS_IRQ_EN, 32'h0);
      chk("irq", 0, irq);
      wr(strc_pkg::OFS_IRQ_CLR, 32'h7);
      rc("irq_stat", strc_pkg::OFS_IRQ_STAT, 32'h0);
      wr(strc_pkg::OFS_INTERVAL, 32'h2);
      wr(strc_pkg::OFS_DELAY, 32'h0);
      wr(strc_pkg::OFS_CTRL, 32'h1);
      rc("status", strc_pkg::OFS_STATUS, st(1, 0, 0, 1));
      smp(20, 0);
      smp(20, 0);
      repeat (3) @(posedge clk_sys);
      wr(strc_pkg::OFS_CTRL, 32'h1 << strc_pkg::CTRL_STOP_REQ);
      rc("status", strc_pkg::OFS_STATUS, st(1, 1, 1, 0));
      rc("count", strc_pkg::OFS_COUNT, 32'h2);
      rc("irq_stat", strc_pkg::OFS_IRQ_STAT, 32'h7);
      rc("start_ptr", strc_pkg::OFS_START_PTR, 32'h0);
      // Abort right after a start: trace ends, no end interrupt, store emptied
      wr(strc_pkg::OFS_IRQ_CLR, 32'h7);
      wr(strc_pkg::OFS_CTRL, 32'h1);
      wr(strc_pkg::OFS_CTRL, 32'h1 << strc_pkg::CTRL_ABORT);
      rc("status", strc_pkg::OFS_STATUS, st(1, 1, 0, 0));
      rc("irq_stat", strc_pkg::OFS_IRQ_STAT, 32'h0);
      rc("count", strc_pkg::OFS_COUNT, 32'h0);
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire
